// file: ebc_defines.svh
// widths, codes and reset values for the external bus controller
`ifndef EBC_DEFINES_SVH
`define EBC_DEFINES_SVH

`define EBC_ADDR_W        22
`define EBC_DATA_W        16
`define EBC_WORD_W        32
`define EBC_PORT_W        7
`define EBC_PORT_ACC_W    8

`define EBC_HALF_STEP     22'h000002
`define EBC_ADDR_RST      22'h000000
`define EBC_DATA_RST      16'h0000
`define EBC_WORD_RST      32'h00000000
`define EBC_PORT_RST      7'h00
`define EBC_PORT_RD_RST   8'h00

`define EBC_SIZE_BYTE     2'h0
`define EBC_SIZE_HALF     2'h1
`define EBC_SIZE_WORD     2'h2

`define EBC_ST_IDLE       3'h0
`define EBC_ST_T1         3'h1
`define EBC_ST_T2         3'h2
`define EBC_ST_TW         3'h3
`define EBC_ST_T3         3'h4
`define EBC_ST_HOLD       3'h5

`endif

// file: ebc_pkg.sv
// types shared by the external bus controller
`include "ebc_defines.svh"
package ebc_pkg;

   typedef enum logic [1:0] {
      EBC_BYTE = `EBC_SIZE_BYTE,
      EBC_HALF = `EBC_SIZE_HALF,
      EBC_WORD = `EBC_SIZE_WORD
   } ebc_size_t;

   typedef enum logic [2:0] {
      ST_IDLE = `EBC_ST_IDLE,
      ST_T1   = `EBC_ST_T1,
      ST_T2   = `EBC_ST_T2,
      ST_TW   = `EBC_ST_TW,
      ST_T3   = `EBC_ST_T3,
      ST_HOLD = `EBC_ST_HOLD
   } ebc_state_t;

   typedef struct packed {
      logic [`EBC_ADDR_W-1:0] addr;
      logic [`EBC_WORD_W-1:0] wdata;
      ebc_size_t              size;
      logic                   write;
   } ebc_req_t;

   typedef struct packed {
      logic lower_byte_enable_n;
      logic upper_byte_enable_n;
      logic read_write_status;
      logic data_strobe_n;
      logic address_latch_strobe_n;
      logic low_byte_write_strobe_n;
      logic high_byte_write_strobe_n;
      logic read_strobe_n;
   } ebc_ctl_t;

   // {upper enable, lower enable, lowest address/data bit}
   typedef struct packed {
      logic ube_n;
      logic lbe_n;
      logic ad0;
   } ebc_lane_t;

   function automatic ebc_lane_t ebc_lanes(input ebc_size_t size, input logic odd);
      ebc_lane_t l;
      l = '{ube_n: 1'b0, lbe_n: 1'b0, ad0: 1'b0};
      if (size == EBC_BYTE)
      begin
         l = odd ? ebc_lane_t'{ube_n: 1'b0, lbe_n: 1'b1, ad0: 1'b1}
                 : ebc_lane_t'{ube_n: 1'b1, lbe_n: 1'b0, ad0: 1'b0};
      end
      return l;
   endfunction

endpackage

// file: ebc_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ns
module ebc_sync #(
   parameter int W = 1
) (
   // clock
   input  wire logic         clk_in,
   // data
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);
   logic [W-1:0] meta_r;
   logic [W-1:0] q_r;

   // first stage feeds only the second
   always_ff @(posedge clk_in)
   begin
      meta_r <= d_in;
      q_r    <= meta_r;
   end

   assign q_out = q_r;
endmodule // ebc_sync

// file: ebc_bus_ctl.sv
// external expansion bus controller: core request side and bus state machine
`timescale 1ns/1ns
`include "ebc_defines.svh"
module ebc_bus_ctl (
   // core clock and reset
   input  wire logic                      clk_in,
   input  wire logic                      rst_n_in,
   // bus clock
   input  wire logic                      bus_clk_in,
   // core request and answer
   input  wire logic                      req_valid_in,
   input  wire ebc_pkg::ebc_req_t         req_in,
   output logic                           req_ready_out,
   output logic                           rsp_valid_out,
   output logic      [`EBC_WORD_W-1:0]    rsp_rdata_out,
   // configuration
   input  wire logic                      memory_expansion_mode_in,
   input  wire logic                      port_alt_function_ctl_in,
   input  wire logic [`EBC_PORT_W-1:0]    bus_port_direction_in,
   // control port register access
   input  wire logic                      port_wr_in,
   input  wire logic [`EBC_PORT_ACC_W-1:0] port_wdata_in,
   output logic      [`EBC_PORT_ACC_W-1:0] port_rdata_out,
   // address pins
   output logic                           bus_clock_output_out,
   output logic      [3:0]                address_bits_1_4_out,
   output logic      [7:0]                address_bits_5_12_out,
   output logic      [8:0]                address_bits_13_21_out,
   output logic                           addr_oe_n_out,
   // multiplexed address/data pins
   output logic      [`EBC_DATA_W-1:0]    ad_out,
   input  wire logic [`EBC_DATA_W-1:0]    ad_in,
   output logic                           ad_oe_n_out,
   // control strobes
   output ebc_pkg::ebc_ctl_t              bus_ctl_out,
   output logic                           bus_ctl_oe_n_out,
   output logic                           hold_acknowledge_n_out,
   input  wire logic                      wait_n_in,
   input  wire logic                      hold_request_n_in,
   // control port pins
   output logic      [`EBC_PORT_W-1:0]    port_pin_out,
   input  wire logic [`EBC_PORT_W-1:0]    port_pin_in,
   output logic      [`EBC_PORT_W-1:0]    port_pin_oe_n_out
);

   typedef struct packed {
      logic                        busy;
      logic                        req_tgl;
      logic                        ack_seen;
      logic                        rsp_valid;
      logic [`EBC_WORD_W-1:0]      rsp_rdata;
      ebc_pkg::ebc_req_t           req;
      logic [`EBC_PORT_W-1:0]      port_latch;
      logic [`EBC_PORT_ACC_W-1:0]  port_rdata;
   } ebc_core_t;

   typedef struct packed {
      ebc_pkg::ebc_state_t         state;
      logic                        seen_tgl;
      logic                        ack_tgl;
      logic                        second;
      logic [`EBC_ADDR_W-1:0]      addr;
      logic                        ube_n;
      logic                        lbe_n;
      logic                        rw;
      logic                        data_strobe_n_n;
      logic                        wrl_n;
      logic                        wrh_n;
      logic                        rd_n;
      logic [`EBC_DATA_W-1:0]      ad;
      logic                        ad_oe_n;
      logic                        addr_oe_n;
      logic                        ctl_oe_n;
      logic                        hold_acknowledge_n_n;
      logic [`EBC_WORD_W-1:0]      rdata;
   } ebc_bus_t;

   typedef struct packed {
      logic                        address_latch_strobe_n_n;
      logic                        wait_hit;
      logic [`EBC_DATA_W-1:0]      rd_lat;
   } ebc_neg_t;

   ebc_core_t                c_r;
   ebc_core_t                c_nxt;
   ebc_bus_t                 b_r;
   ebc_bus_t                 b_nxt;
   ebc_neg_t                 n_r;
   ebc_neg_t                 n_nxt;
   logic                     bus_rst_n;
   logic [3:0]               bus_sync;
   logic                     b_req_tgl;
   logic                     b_hold;
   logic                     b_exp_mode;
   logic                     b_wait_en;
   logic [`EBC_PORT_W:0]     core_sync;
   logic                     c_ack_tgl;
   logic [`EBC_PORT_W-1:0]   c_pins;
   logic [`EBC_PORT_W-1:0]   ctl_pins;
   logic [`EBC_PORT_W-1:0]   ctl_pins_oe_n;

   // state names in scope without importing the package
   localparam ebc_pkg::ebc_state_t ST_IDLE = ebc_pkg::ST_IDLE;
   localparam ebc_pkg::ebc_state_t ST_T1   = ebc_pkg::ST_T1;
   localparam ebc_pkg::ebc_state_t ST_T2   = ebc_pkg::ST_T2;
   localparam ebc_pkg::ebc_state_t ST_TW   = ebc_pkg::ST_TW;
   localparam ebc_pkg::ebc_state_t ST_T3   = ebc_pkg::ST_T3;
   localparam ebc_pkg::ebc_state_t ST_HOLD = ebc_pkg::ST_HOLD;

   // crossings into the bus clock domain
   ebc_sync #(.W(1)) u_rst_sync (
      .clk_in (bus_clk_in),
      .d_in   (rst_n_in),
      .q_out  (bus_rst_n)
   );

   ebc_sync #(.W(4)) u_bus_sync (
      .clk_in (bus_clk_in),
      .d_in   ({c_r.req_tgl, hold_request_n_in, memory_expansion_mode_in,
                port_alt_function_ctl_in}),
      .q_out  (bus_sync)
   );

   assign b_req_tgl  = bus_sync[3];
   assign b_hold     = ~bus_sync[2];
   assign b_exp_mode = bus_sync[1];
   assign b_wait_en  = bus_sync[0];

   // crossings into the core clock domain
   ebc_sync #(.W(`EBC_PORT_W+1)) u_core_sync (
      .clk_in (clk_in),
      .d_in   ({b_r.ack_tgl, port_pin_in}),
      .q_out  (core_sync)
   );

   assign c_ack_tgl = core_sync[`EBC_PORT_W];
   assign c_pins    = core_sync[`EBC_PORT_W-1:0];

   // core side: request stays frozen while busy and rdata from the ack toggle until the next access, so the
   // toggle handshake carries the words safely across
   always_comb
   begin
      c_nxt           = c_r;
      c_nxt.rsp_valid = 1'b0;
      if (req_valid_in && !c_r.busy)
      begin
         c_nxt.req     = req_in;
         c_nxt.busy    = 1'b1;
         c_nxt.req_tgl = ~c_r.req_tgl;
      end
      if (c_r.busy && (c_ack_tgl != c_r.ack_seen))
      begin
         c_nxt.ack_seen  = c_ack_tgl;
         c_nxt.busy      = 1'b0;
         c_nxt.rsp_valid = 1'b1;
         c_nxt.rsp_rdata = b_r.rdata;
      end
      if (port_wr_in)
      begin
         c_nxt.port_latch = port_wdata_in[`EBC_PORT_W-1:0];
      end
      c_nxt.port_rdata = {1'b0, c_pins};
   end

   always_ff @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         c_r.busy       <= 1'b0;
         c_r.req_tgl    <= 1'b0;
         c_r.ack_seen   <= 1'b0;
         c_r.rsp_valid  <= 1'b0;
         c_r.rsp_rdata  <= `EBC_WORD_RST;
         c_r.req        <= '0;
         c_r.port_latch <= `EBC_PORT_RST;
         c_r.port_rdata <= `EBC_PORT_RD_RST;
      end
      else
      begin
         c_r <= c_nxt;
      end
   end

   // bus side state machine on the bus clock
   always_comb
   begin
      ebc_pkg::ebc_lane_t     ln;
      logic [`EBC_ADDR_W-1:0] a;
      logic [`EBC_WORD_W-1:0] rd;
      ln    = '0;
      a     = '0;
      rd    = b_r.rdata;
      b_nxt = b_r;
      unique case (b_r.state)
         ST_IDLE:
         begin
            b_nxt.rw      = 1'b1;
            b_nxt.ad_oe_n = 1'b1;
            if (b_hold)
            begin
               b_nxt.state     = ST_HOLD;
               b_nxt.hold_acknowledge_n_n   = 1'b0;
               b_nxt.addr_oe_n = 1'b1;
               b_nxt.ctl_oe_n  = 1'b1;
            end
            else if ((b_req_tgl != b_r.seen_tgl) && b_exp_mode)
            begin
               b_nxt.seen_tgl = b_req_tgl;
               b_nxt.second   = 1'b0;
               b_nxt.state    = ST_T1;
               a  = c_r.req.addr;
               ln = ebc_pkg::ebc_lanes(c_r.req.size, a[0]);
               if (c_r.req.size != ebc_pkg::EBC_BYTE)
               begin
                  a[0] = 1'b0;
               end
               if (c_r.req.size == ebc_pkg::EBC_WORD)
               begin
                  a[1] = 1'b0;
               end
               b_nxt.addr    = {a[`EBC_ADDR_W-1:1], ln.ad0};
               b_nxt.ube_n   = ln.ube_n;
               b_nxt.lbe_n   = ln.lbe_n;
               b_nxt.rw      = ~c_r.req.write;
               b_nxt.ad      = {a[`EBC_DATA_W-1:1], ln.ad0};
               b_nxt.ad_oe_n = 1'b0;
            end
         end
         ST_T1:
         begin
            b_nxt.state  = ST_T2;
            b_nxt.data_strobe_n_n = 1'b0;
            b_nxt.rd_n   = ~b_r.rw;
            b_nxt.wrl_n  = b_r.rw | b_r.lbe_n;
            b_nxt.wrh_n  = b_r.rw | b_r.ube_n;
            if (b_r.rw)
            begin
               b_nxt.ad_oe_n = 1'b1; // read: the far side drives data
            end
            else if (c_r.req.size == ebc_pkg::EBC_BYTE)
            begin
               b_nxt.ad = {c_r.req.wdata[7:0], c_r.req.wdata[7:0]};
            end
            else if (b_r.second)
            begin
               b_nxt.ad = c_r.req.wdata[`EBC_WORD_W-1:`EBC_DATA_W];
            end
            else
            begin
               b_nxt.ad = c_r.req.wdata[`EBC_DATA_W-1:0];
            end
         end
         ST_T2, ST_TW:
         begin
            if (n_r.wait_hit)
            begin
               b_nxt.state = ST_TW;
            end
            else
            begin
               b_nxt.state  = ST_T3;
               b_nxt.data_strobe_n_n = 1'b1;
               b_nxt.rd_n   = 1'b1;
               b_nxt.wrl_n  = 1'b1;
               b_nxt.wrh_n  = 1'b1;
            end
         end
         ST_T3:
         begin
            if (c_r.req.size == ebc_pkg::EBC_BYTE)
            begin
               rd = {24'h000000, b_r.addr[0] ? n_r.rd_lat[15:8] : n_r.rd_lat[7:0]};
            end
            else if (b_r.second)
            begin
               rd = {n_r.rd_lat, b_r.rdata[`EBC_DATA_W-1:0]};
            end
            else
            begin
               rd = {16'h0000, n_r.rd_lat};
            end
            b_nxt.rdata = rd;
            // a word runs as two back-to-back halfword cycles, never split by hold
            if ((c_r.req.size == ebc_pkg::EBC_WORD) && !b_r.second)
            begin
               b_nxt.second  = 1'b1;
               b_nxt.state   = ST_T1;
               a             = b_r.addr + `EBC_HALF_STEP;
               b_nxt.addr    = a;
               b_nxt.ad      = a[`EBC_DATA_W-1:0];
               b_nxt.ad_oe_n = 1'b0;
            end
            else
            begin
               b_nxt.ack_tgl = ~b_r.ack_tgl;
               b_nxt.rw      = 1'b1;
               b_nxt.ad_oe_n = 1'b1;
               if (b_hold)
               begin
                  b_nxt.state     = ST_HOLD;
                  b_nxt.hold_acknowledge_n_n   = 1'b0;
                  b_nxt.addr_oe_n = 1'b1;
                  b_nxt.ctl_oe_n  = 1'b1;
               end
               else
               begin
                  b_nxt.state = ST_IDLE;
               end
            end
         end
         ST_HOLD:
         begin
            b_nxt.ad_oe_n = 1'b1;
            if (!b_hold)
            begin
               b_nxt.state     = ST_IDLE;
               b_nxt.hold_acknowledge_n_n   = 1'b1;
               b_nxt.addr_oe_n = 1'b0;
               b_nxt.ctl_oe_n  = 1'b0;
            end
         end
         default:
         begin
            b_nxt.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge bus_clk_in)
   begin
      if (!bus_rst_n)
      begin
         b_r.state     <= ST_IDLE;
         b_r.seen_tgl  <= b_req_tgl;
         b_r.ack_tgl   <= 1'b0;
         b_r.second    <= 1'b0;
         b_r.addr      <= `EBC_ADDR_RST;
         b_r.ube_n     <= 1'b1;
         b_r.lbe_n     <= 1'b1;
         b_r.rw        <= 1'b1;
         b_r.data_strobe_n_n    <= 1'b1;
         b_r.wrl_n     <= 1'b1;
         b_r.wrh_n     <= 1'b1;
         b_r.rd_n      <= 1'b1;
         b_r.ad        <= `EBC_DATA_RST;
         b_r.ad_oe_n   <= 1'b1;
         b_r.addr_oe_n <= 1'b0;
         b_r.ctl_oe_n  <= 1'b0;
         b_r.hold_acknowledge_n_n   <= 1'b1;
         b_r.rdata     <= `EBC_WORD_RST;
      end
      else
      begin
         b_r <= b_nxt;
      end
   end

   // falling-edge events: latch strobe, wait sample, read data capture
   always_comb
   begin
      n_nxt = n_r;
      unique case (b_r.state)
         ST_T1:
         begin
            n_nxt.address_latch_strobe_n_n = 1'b0;
         end
         ST_T3, ST_IDLE, ST_HOLD:
         begin
            n_nxt.address_latch_strobe_n_n = 1'b1;
         end
         default:
         begin
            n_nxt.address_latch_strobe_n_n = n_r.address_latch_strobe_n_n;
         end
      endcase
      n_nxt.wait_hit = ((b_r.state == ST_T2) || (b_r.state == ST_TW))
                       && b_wait_en && !wait_n_in;
      if (b_r.state == ST_T3)
      begin
         n_nxt.rd_lat = ad_in;
      end
   end

   always_ff @(negedge bus_clk_in)
   begin
      if (!bus_rst_n)
      begin
         n_r.address_latch_strobe_n_n   <= 1'b1;
         n_r.wait_hit <= 1'b0;
         n_r.rd_lat   <= `EBC_DATA_RST;
      end
      else
      begin
         n_r <= n_nxt;
      end
   end

   // outputs
   assign req_ready_out          = ~c_r.busy;
   assign rsp_valid_out          = c_r.rsp_valid;
   assign rsp_rdata_out          = c_r.rsp_rdata;
   assign port_rdata_out         = c_r.port_rdata;
   assign bus_clock_output_out   = bus_clk_in;
   assign address_bits_1_4_out   = b_r.addr[4:1];
   assign address_bits_5_12_out  = b_r.addr[12:5];
   assign address_bits_13_21_out = b_r.addr[21:13];
   assign addr_oe_n_out          = b_r.addr_oe_n;
   assign ad_out                 = b_r.ad;
   assign ad_oe_n_out            = b_r.ad_oe_n;
   assign bus_ctl_oe_n_out       = b_r.ctl_oe_n;
   assign hold_acknowledge_n_out = b_r.hold_acknowledge_n_n;

   assign bus_ctl_out.lower_byte_enable_n      = b_r.lbe_n;
   assign bus_ctl_out.upper_byte_enable_n      = b_r.ube_n;
   assign bus_ctl_out.read_write_status        = b_r.rw;
   assign bus_ctl_out.data_strobe_n            = b_r.data_strobe_n_n;
   assign bus_ctl_out.address_latch_strobe_n   = n_r.address_latch_strobe_n_n;
   assign bus_ctl_out.low_byte_write_strobe_n  = b_r.wrl_n;
   assign bus_ctl_out.high_byte_write_strobe_n = b_r.wrh_n;
   assign bus_ctl_out.read_strobe_n            = b_r.rd_n;

   // control port pins; hold acknowledge keeps driving while the rest float
   assign ctl_pins      = {b_r.rd_n, b_r.hold_acknowledge_n_n, n_r.address_latch_strobe_n_n, b_r.data_strobe_n_n,
                           b_r.rw, b_r.ube_n, b_r.lbe_n};
   assign ctl_pins_oe_n = {b_r.ctl_oe_n, 1'b0, {5{b_r.ctl_oe_n}}};
   assign port_pin_out      = memory_expansion_mode_in ? ctl_pins
                                                       : c_r.port_latch;
   assign port_pin_oe_n_out = memory_expansion_mode_in ? ctl_pins_oe_n
                                                       : bus_port_direction_in;

endmodule // ebc_bus_ctl

// file: ebc_bus_ctl_props.sv
// bus pin assertions for the external bus controller
`timescale 1ns/1ns
module ebc_bus_ctl_props (
   // bus clock and reset
   input wire logic              bus_clk_in,
   input wire logic              rst_n_in,
   // observed pins
   input wire logic              port_alt_function_ctl_in,
   input wire ebc_pkg::ebc_ctl_t bus_ctl_out,
   input wire logic [15:0]       ad_out,
   input wire logic              ad_oe_n_out,
   input wire logic              addr_oe_n_out,
   input wire logic              bus_ctl_oe_n_out,
   input wire logic              hold_acknowledge_n_out,
   input wire logic [3:0]        address_bits_1_4_out,
   input wire logic [7:0]        address_bits_5_12_out,
   input wire logic [8:0]        address_bits_13_21_out
);
   ebc_pkg::ebc_ctl_t c;
   logic              hk;
   assign c  = bus_ctl_out;
   assign hk = hold_acknowledge_n_out;
   default clocking @(posedge bus_clk_in); endclocking
   default disable iff (!rst_n_in);
   chk_lane_code: assert property ($fell(c.address_latch_strobe_n) |->
      ad_out[0] == c.lower_byte_enable_n && !(c.lower_byte_enable_n && c.upper_byte_enable_n))
      else $error("byte lane code wrong");
   chk_addr_kept: assert property ($changed({address_bits_13_21_out, address_bits_5_12_out,
      address_bits_1_4_out, c.lower_byte_enable_n, c.upper_byte_enable_n}) |-> !ad_oe_n_out)
      else $error("address moved outside first state");
   chk_rw_idle: assert property ((ad_oe_n_out && c.address_latch_strobe_n && hk)
      |-> c.read_write_status) else $error("status low while idle");
   chk_strobe_order: assert property ($fell(c.data_strobe_n) |-> !c.address_latch_strobe_n)
      else $error("data strobe before latch strobe");
   chk_no_wait: assert property ((!port_alt_function_ctl_in && $fell(c.data_strobe_n))
      |=> c.data_strobe_n) else $error("wait honoured while disabled");
   chk_latch_release: assert property ($rose(c.address_latch_strobe_n)
      |-> c.data_strobe_n && c.read_strobe_n) else $error("latch strobe rose early");
   chk_latch_fall: assert property ($fell(c.address_latch_strobe_n)
      |-> !ad_oe_n_out && c.data_strobe_n) else $error("latch strobe fell outside first state");
   chk_read_strobe: assert property ((c.read_write_status && hk)
      |-> c.read_strobe_n == c.data_strobe_n) else $error("read strobe off data strobe");
   chk_write_strobes: assert property ((!c.read_write_status && hk) |-> c.read_strobe_n &&
      c.low_byte_write_strobe_n == (c.data_strobe_n | c.lower_byte_enable_n) &&
      c.high_byte_write_strobe_n == (c.data_strobe_n | c.upper_byte_enable_n))
      else $error("write strobes off data strobe");
   chk_hold_float: assert property (!hk |-> addr_oe_n_out && bus_ctl_oe_n_out && ad_oe_n_out)
      else $error("bus driven during hold");
   chk_read_float: assert property (!c.read_strobe_n |-> ad_oe_n_out)
      else $error("muxed lines driven in read data phase");
   cov_write: cover property ($fell(c.data_strobe_n) && !c.read_write_status);
   cov_read: cover property ($fell(c.read_strobe_n));
   cov_wait: cover property (!c.data_strobe_n [*3]);
   cov_hold: cover property ($fell(hk));
endmodule // ebc_bus_ctl_props

bind ebc_bus_ctl ebc_bus_ctl_props ebc_bus_ctl_props_inst (.bus_clk_in, .rst_n_in,
   .port_alt_function_ctl_in, .bus_ctl_out, .ad_out, .ad_oe_n_out, .addr_oe_n_out,
   .bus_ctl_oe_n_out, .hold_acknowledge_n_out, .address_bits_1_4_out,
   .address_bits_5_12_out, .address_bits_13_21_out);

// file: ebc_ext_mem.sv
// external memory and wait source on the far side of the bus
`timescale 1ns/1ns
module ebc_ext_mem (
   // bus side
   input  wire logic              bus_clk_in,
   input  wire ebc_pkg::ebc_ctl_t bus_ctl_in,
   input  wire logic [15:0]       ad_in,
   output logic      [15:0]       ad_out,
   output logic                   wait_n_out,
   // bench side
   input  wire logic [3:0]        wait_cycles_in,
   output logic      [15:0]       wr_data_out,
   output logic      [1:0]        wr_lanes_out,
   output logic      [3:0]        strobe_len_out
);
   logic [15:0] addr_r;
   logic [3:0]  run_r = 4'h0;
   logic        rd_r  = 1'b0;
   wire         address_latch_strobe_n_n = bus_ctl_in.address_latch_strobe_n;
   wire         data_strobe_n_n = bus_ctl_in.data_strobe_n;
   initial strobe_len_out = 4'h0;
   always @(negedge address_latch_strobe_n_n) addr_r <= ad_in;
   // data held through the final state; released lines show the inverse, not a stale value
   assign ad_out = (rd_r || !bus_ctl_in.read_strobe_n) ? (addr_r ^ 16'h5a3c) : ~ad_in;
   assign wait_n_out = !(!data_strobe_n_n && run_r < wait_cycles_in);
   always @(posedge bus_clk_in)
   begin
      rd_r <= !bus_ctl_in.read_strobe_n;
      run_r <= data_strobe_n_n ? 4'h0 : run_r + 4'h1;
      if (data_strobe_n_n && run_r != 4'h0)
         strobe_len_out <= run_r;
   end
   always @(negedge bus_clk_in)
      if (!data_strobe_n_n && !bus_ctl_in.read_write_status)
      begin
         wr_data_out <= ad_in;
         wr_lanes_out <= {bus_ctl_in.upper_byte_enable_n, bus_ctl_in.lower_byte_enable_n};
      end
endmodule // ebc_ext_mem

// file: tb.sv
// self-checking bench for the external bus controller
`timescale 1ns/1ns
module tb;
   logic clk_in = 1'b0, rst_n_in = 1'b0, bus_clk = 1'b0, req_valid = 1'b0, mode = 1'b0;
   logic alt = 1'b0, port_wr = 1'b0, hreq_n = 1'b1, ready, rsp_valid, ad_oe_n, addr_oe_n;
   logic ctl_oe_n, hold_acknowledge_n_n, wait_n;
   logic [6:0] dir = 7'h00, pin_out, pin_oe_n, pin_in;
   logic [7:0] port_wdata = 8'h00, port_rdata;
   logic [31:0] rdata, rd;
   logic [15:0] ad_dev, ad_mem, wr_data;
   logic [3:0] a14, wait_cycles = 4'h0, slen;
   logic [7:0] a512;
   logic [8:0] a1321;
   logic [1:0] lanes;
   ebc_pkg::ebc_req_t req = '0;
   ebc_pkg::ebc_ctl_t ctl;
   int err_count = 0, tests_run = 0;
   always #10 clk_in = ~clk_in;
   initial #3 forever #6 bus_clk = ~bus_clk;
   assign pin_in = pin_out | pin_oe_n;
   ebc_bus_ctl ebc_bus_ctl_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_clk_in(bus_clk),
      .req_valid_in(req_valid), .req_in(req), .req_ready_out(ready), .rsp_valid_out(rsp_valid),
      .rsp_rdata_out(rdata), .memory_expansion_mode_in(mode), .port_alt_function_ctl_in(alt),
      .bus_port_direction_in(dir), .port_wr_in(port_wr), .port_wdata_in(port_wdata),
      .port_rdata_out(port_rdata), .bus_clock_output_out(), .address_bits_1_4_out(a14),
      .address_bits_5_12_out(a512), .address_bits_13_21_out(a1321), .addr_oe_n_out(addr_oe_n),
      .ad_out(ad_dev), .ad_in(ad_mem), .ad_oe_n_out(ad_oe_n), .bus_ctl_out(ctl),
      .bus_ctl_oe_n_out(ctl_oe_n), .hold_acknowledge_n_out(hold_acknowledge_n_n), .wait_n_in(wait_n),
      .hold_request_n_in(hreq_n), .port_pin_out(pin_out), .port_pin_in(pin_in),
      .port_pin_oe_n_out(pin_oe_n));
   ebc_ext_mem ebc_ext_mem_inst (.bus_clk_in(bus_clk), .bus_ctl_in(ctl), .ad_in(ad_dev),
      .ad_out(ad_mem), .wait_n_out(wait_n), .wait_cycles_in(wait_cycles),
      .wr_data_out(wr_data), .wr_lanes_out(lanes), .strobe_len_out(slen));
   function automatic logic [15:0] mem(input logic [15:0] a);
      return a ^ 16'h5a3c;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one access; request held until the edge that takes it
   task automatic do_req(input logic wr, input ebc_pkg::ebc_size_t sz, input logic [21:0] a,
      input logic [31:0] wd, output logic [31:0] r);
      int n;
      n = 0;
      @(negedge clk_in);
      req = '{addr: a, wdata: wd, size: sz, write: wr};
      req_valid = 1'b1;
      while (ready !== 1'b1 && n < 500)
      begin
         @(negedge clk_in);
         n++;
      end
      @(negedge clk_in);
      req_valid = 1'b0;
      while (rsp_valid !== 1'b1 && n < 500)
      begin
         @(negedge clk_in);
         n++;
      end
      r = rdata;
      chk(n < 500, 1);
   endtask
   task automatic t_port();
      @(negedge clk_in);
      port_wr = 1'b1;
      port_wdata = 8'hff;
      @(negedge clk_in);
      port_wr = 1'b0;
      repeat (6) @(negedge clk_in);
      chk(port_rdata, 8'h7f);
      chk(pin_oe_n, 7'h00);
      dir = 7'h55;
      repeat (4) @(negedge clk_in);
      chk(pin_oe_n, 7'h55);
      mode = 1'b1;
      repeat (6) @(negedge clk_in);
      chk(pin_oe_n, 7'h00);
   endtask
   task automatic t_reads();
      logic [21:0] a [4] = '{22'h012344, 22'h000101, 22'h000100, 22'h001236};
      ebc_pkg::ebc_size_t s [4] = '{ebc_pkg::EBC_HALF, ebc_pkg::EBC_BYTE, ebc_pkg::EBC_BYTE,
         ebc_pkg::EBC_WORD};
      logic [31:0] e [4];
      e[0] = {16'h0, mem(16'h2344)};
      e[1] = {24'h0, 8'(mem(16'h0101) >> 8)};
      e[2] = {24'h0, 8'(mem(16'h0100))};
      e[3] = {mem(16'h1236), mem(16'h1234)};
      for (int i = 0; i < 4; i++)
      begin
         do_req(1'b0, s[i], a[i], 32'h0, rd);
         chk(rd, e[i]);
      end
      chk({a1321, a512, a14}, 22'h001236 >> 1);
      chk({ctl.upper_byte_enable_n, ctl.lower_byte_enable_n, ctl.read_write_status}, 3'h1);
   endtask
   task automatic t_writes();
      do_req(1'b1, ebc_pkg::EBC_BYTE, 22'h000201, 32'h000000a7, rd);
      chk({lanes, wr_data}, {2'h1, 16'ha7a7});
      do_req(1'b1, ebc_pkg::EBC_BYTE, 22'h000200, 32'h0000005e, rd);
      chk({lanes, wr_data}, {2'h2, 16'h5e5e});
      do_req(1'b1, ebc_pkg::EBC_WORD, 22'h000300, 32'hbeef1234, rd);
      chk({lanes, wr_data}, {2'h0, 16'hbeef});
      chk(ctl.read_write_status, 1);
   endtask
   task automatic t_wait();
      alt = 1'b1;
      wait_cycles = 4'h3;
      do_req(1'b0, ebc_pkg::EBC_HALF, 22'h000400, 32'h0, rd);
      chk({slen, rd[15:0]}, {4'h4, mem(16'h0400)});
      alt = 1'b0;
      repeat (6) @(negedge clk_in);
      do_req(1'b0, ebc_pkg::EBC_HALF, 22'h000402, 32'h0, rd);
      chk({slen, rd[15:0]}, {4'h1, mem(16'h0402)});
      wait_cycles = 4'h0;
   endtask
   // hold raised while a word access runs: the access completes first
   task automatic t_hold();
      int n;
      fork
         do_req(1'b0, ebc_pkg::EBC_WORD, 22'h002000, 32'h0, rd);
         begin
            repeat (3) @(negedge clk_in);
            hreq_n = 1'b0;
         end
      join
      chk(rd, {mem(16'h2002), mem(16'h2000)});
      n = 0;
      while (hold_acknowledge_n_n !== 1'b0 && n < 40)
      begin
         @(negedge clk_in);
         n++;
      end
      chk({hold_acknowledge_n_n, addr_oe_n, ctl_oe_n, ad_oe_n}, 4'h7);
      fork
         do_req(1'b0, ebc_pkg::EBC_HALF, 22'h002010, 32'h0, rd);
         begin
            repeat (30) @(negedge clk_in);
            chk({hold_acknowledge_n_n, addr_oe_n, ctl_oe_n, ad_oe_n}, 4'h7);
            hreq_n = 1'b1;
         end
      join
      chk(rd, {16'h0, mem(16'h2010)});
   endtask
   task automatic end_of_test();
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk_in);
      @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
      t_port();
      t_reads();
      t_writes();
      t_wait();
      t_hold();
      end_of_test();
   end
   initial
   begin
      #100000;
      err_count++;
      end_of_test();
   end
endmodule // tb
